// *** dv/parmux_board_model.sv ***
`timescale 1ns/1ps

// ----------------------------------------
// Board side: reset switch and line loads
// ----------------------------------------
module parmux_board_model
  import parmux_pkg::*;
(
  // Reset switch, high pulls the reset pin low
  input wire logic rst_press,
  // Pad drive from the chip
  input wire parmux_pad_s pad0,
  input wire parmux_pad_s pad1,
  input wire parmux_pad_s pad2,
  input wire parmux_pad_s pad7,
  // Line levels seen at the pads, {bit7, bit2, bit1, bit0}
  output logic [3:0] line_in
);
  // Port lines carry a weak board pull-down, so an unpulled input never floats
  assign line_in[0] = !pad0.oe_n ? pad0.out : pad0.pull_up;
  assign line_in[1] = !pad1.oe_n ? pad1.out : pad1.pull_up;
  assign line_in[2] = !pad2.oe_n ? pad2.out : pad2.pull_up;
  // Reset pin has a board pull-up; the switch wins over the chip's drive
  assign line_in[3] = rst_press ? 1'b0 : (!pad7.oe_n ? pad7.out : 1'b1);
endmodule : parmux_board_model

// *** dv/tb_top.sv ***
`timescale 1ns/1ps

module tb_top;
  import parmux_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic por_req = 1'b0;
  logic wdog = 1'b0;
  logic sw_req = 1'b0;
  logic gsel = 1'b0;
  logic press = 1'b0;
  logic [2:0] pwm = 3'h0;
  parmux_cfg_s c0 = '0, c1 = '0, c2 = '0, c7 = '0;
  parmux_pad_s p0, p1, p2, p7;
  logic [3:0] lines, val;
  logic crst, mode;
  int bad_count = 0;
  int total_checks = 0;
  int n;
  logic [5:0] alt_view;

  // Pulse outputs and drive enables of bits 0 to 2, packed for one compare
  assign alt_view = {p0.out, p1.out, p2.out, p0.oe_n, p1.oe_n, p2.oe_n};

  // ----------------------------------------
  // Clock, design and board
  // ----------------------------------------
  // Free-running 40 MHz clock
  always #12.5 sys_clk = ~sys_clk;

  parmux_top dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .por_req(por_req),
    .watchdog_timeout_reset(wdog), .sw_reset_req(sw_req), .rst_pin_gpio_sel(gsel),
    .port_a_bit7_cfg(c7), .port_a_bit0_cfg(c0), .port_a_bit1_cfg(c1),
    .port_a_bit2_cfg(c2), .pulse_channel_zero(pwm[0]), .pulse_channel_one(pwm[1]),
    .pulse_channel_two(pwm[2]), .port_a_bit0_line_in(lines[0]),
    .port_a_bit1_line_in(lines[1]), .port_a_bit2_line_in(lines[2]),
    .port_a_bit7_line_in(lines[3]), .port_a_bit0_line(p0), .port_a_bit1_line(p1),
    .port_a_bit2_line(p2), .port_a_bit7_line(p7), .port_a_value(val),
    .chip_rst_n_reg(crst), .rst_pin_gpio_mode_reg(mode));

  parmux_board_model board_u (.rst_press(press), .pad0(p0), .pad1(p1), .pad2(p2),
    .pad7(p7), .line_in(lines));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // Lets the edge's updates land before sampling
  task automatic step(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask : step

  // Bounded wait for the internal reset to lift; n counts edges
  task automatic wait_up();
    n = 0;
    while (crst !== 1'b1 && n < 80) begin
      step(1);
      n++;
    end
  endtask : wait_up

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : final_report

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Output pin, then a switch press: pin falls back to pulled input
  task automatic t_pin_reset();
    @(posedge sys_clk);
    c0 <= 4'hc;
    step(2);
    chk(16'(p0), 16'h4, "bit0 output high");
    @(posedge sys_clk);
    press <= 1'b1;
    step(4);
    chk(16'(crst), 16'h0, "pin reset held");
    chk(16'({p0, p1, p2, p7}), 16'h06db, "pads in reset");
    @(posedge sys_clk);
    press <= 1'b0;
    c0 <= 4'h0;
    wait_up();
    chk(16'(n >= 32 && n <= 40), 16'h1, "release count");
  endtask : t_pin_reset

  // Pulse channels need both enables; either alone leaves a port input
  task automatic t_alt();
    @(posedge sys_clk);
    {c0, c1, c2} <= {4'h3, 4'h3, 4'h3};
    pwm <= 3'b101;
    step(2);
    chk(16'(alt_view), 16'h28, "pulse a");
    @(posedge sys_clk);
    pwm <= 3'b010;
    step(2);
    chk(16'(alt_view), 16'h10, "pulse b");
    @(posedge sys_clk);
    {c0, c1, c2} <= {4'h2, 4'h1, 4'h0};
    step(2);
    chk(16'({p0, p1, p2}), 16'h0db, "half enable");
  endtask : t_alt

  // Mixed directions on neighbouring pins, read back through the pads
  task automatic t_dir();
    @(posedge sys_clk);
    {c0, c1, c2} <= {4'hc, 4'h0, 4'h8};
    step(4);
    chk(16'({p0, p1, p2}), 16'h118, "mixed dirs");
    chk(16'(val), 16'h3, "read back");
    @(posedge sys_clk);
    {c0, c1, c2} <= 12'h000;
  endtask : t_dir

  // Port mode ignores the switch; other sources still reset and restore the pin
  task automatic t_gpio_mode();
    for (int k = 0; k < 3; k++) begin
      @(posedge sys_clk);
      gsel <= 1'b1;
      c7 <= 4'hc;
      step(2);
      chk(16'(mode), 16'h1, "port mode");
      chk(16'(p7), 16'h4, "bit7 port output");
      chk(16'(val[3]), 16'h1, "bit7 reads high");
      @(posedge sys_clk);
      press <= 1'b1;
      step(6);
      chk(16'(crst), 16'h1, "switch ignored");
      chk(16'(val[3]), 16'h0, "bit7 reads switch");
      @(posedge sys_clk);
      press <= 1'b0;
      {por_req, wdog, sw_req} <= 3'(3'h1 << k);
      step(5);
      chk(16'(crst), 16'h0, "other source");
      chk(16'(mode), 16'h0, "pin restored");
      @(posedge sys_clk);
      {por_req, wdog, sw_req} <= 3'h0;
      gsel <= 1'b0;
      wait_up();
      chk(16'(n <= 40), 16'h1, "source release");
    end
  endtask : t_gpio_mode

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    step(2);
    chk(16'({p0, p1, p2, p7}), 16'h06db, "pads at reset");
    chk(16'({crst, mode}), 16'h0, "reset state");
    step(1);
    @(posedge sys_clk);
    rst_n <= 1'b1;
    wait_up();
    chk(16'(n >= 32 && n <= 40), 16'h1, "first release");
    t_pin_reset();
    t_alt();
    t_dir();
    t_gpio_mode();
    final_report();
  end

  // Whole run needs well under a thousand cycles
  initial begin
    #100000;
    bad_count++;
    $display("Error at %0t: run hung", $time);
    final_report();
  end
endmodule : tb_top

// *** rtl/parmux_params.svh ***
`ifndef PARMUX_PARAMS_SVH
`define PARMUX_PARAMS_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
// Internal clock cycles spent in the count state before internal release
`define PARMUX_RST_RELEASE_CYCLES 8'h20
`define PARMUX_RST_CNT_W 8

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PARMUX_PULLUP_RESET 1'b1
`define PARMUX_RST_MODE_RESET 1'b0

`endif

// *** rtl/parmux_pin_cell.sv ***
`timescale 1ns/1ps
`include "parmux_params.svh"

// One muxed port pin: general-purpose or pulse output, registered pad drive.
module parmux_pin_cell
  import parmux_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Internal reset still active
  input wire logic in_reset,
  // Configuration and alternate source
  input wire parmux_cfg_s cfg,
  input wire logic alt_out,
  // Pad side
  input wire logic pad_in,
  output parmux_pad_s pad,
  output logic pin_value
);

  logic sync1_reg;
  logic sync2_reg;
  logic use_alt;
  parmux_pad_s pad_next;

  // Alternate needs both enables before it takes the pin
  assign use_alt = cfg.alt_per & cfg.alt_sel;

  // Pad next state; in reset an input with pull-up
  always_comb begin
    pad_next.out = 1'b0;
    pad_next.oe_n = 1'b1;
    pad_next.pull_up = `PARMUX_PULLUP_RESET;
    if (in_reset) begin
      pad_next.oe_n = 1'b1;
    end else if (use_alt) begin
      pad_next.out = alt_out;
      pad_next.oe_n = 1'b0;
      pad_next.pull_up = 1'b0;
    end else begin
      pad_next.out = cfg.data_out;
      pad_next.oe_n = ~cfg.dir_out;
      pad_next.pull_up = ~cfg.dir_out;
    end
  end

  // Pad register and input synchroniser
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pad <= '{out: 1'b0, oe_n: 1'b1, pull_up: `PARMUX_PULLUP_RESET};
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
    end else begin
      pad <= pad_next;
      sync1_reg <= pad_in;
      sync2_reg <= sync1_reg;
    end
  end

  assign pin_value = sync2_reg;

endmodule : parmux_pin_cell

// *** rtl/parmux_pkg.sv ***
package parmux_pkg;

  // Internal reset sequencer states
  typedef enum logic [1:0] {
    PARMUX_ST_HOLD = 2'b00,
    PARMUX_ST_COUNT = 2'b01,
    PARMUX_ST_RUN = 2'b10
  } parmux_rst_e;

  // Pad drive for one pin: output value, enable (low drives), pull-up
  typedef struct packed {
    logic out;
    logic oe_n;
    logic pull_up;
  } parmux_pad_s;

  // Software configuration for one port bit
  typedef struct packed {
    logic dir_out;
    logic data_out;
    logic alt_per;
    logic alt_sel;
  } parmux_cfg_s;

endpackage : parmux_pkg

// *** rtl/parmux_top.sv ***
`timescale 1ns/1ps
`include "parmux_params.svh"

// Notes on behaviour
// - Reset pin low holds whole chip reset
// - Release after fixed internal clock count
// - Port bit seven mode ignores reset pin
// - Then only power-on, watchdog, software reset
// - Any reset returns pin to reset function
// - Each pin direction set independently
// - Bit0 defaults port, alternate drives channel zero
// - Bit1 defaults port, alternate drives channel one
// - Bit2 defaults port, alternate drives channel two
// - Alternate needs peripheral enable and select
module parmux_top
  import parmux_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Other reset sources
  input wire logic por_req,
  input wire logic watchdog_timeout_reset,
  input wire logic sw_reset_req,
  // Reset pin control: 1 selects port bit 7 use
  input wire logic rst_pin_gpio_sel,
  input wire parmux_cfg_s port_a_bit7_cfg,
  // Port bits 0 to 2 configuration
  input wire parmux_cfg_s port_a_bit0_cfg,
  input wire parmux_cfg_s port_a_bit1_cfg,
  input wire parmux_cfg_s port_a_bit2_cfg,
  // Pulse sources
  input wire logic pulse_channel_zero,
  input wire logic pulse_channel_one,
  input wire logic pulse_channel_two,
  // Pads
  input wire logic port_a_bit0_line_in,
  input wire logic port_a_bit1_line_in,
  input wire logic port_a_bit2_line_in,
  input wire logic port_a_bit7_line_in,
  output parmux_pad_s port_a_bit0_line,
  output parmux_pad_s port_a_bit1_line,
  output parmux_pad_s port_a_bit2_line,
  output parmux_pad_s port_a_bit7_line,
  // Synchronised pin values
  output logic [3:0] port_a_value,
  // Internal chip reset, low active
  output logic chip_rst_n_reg,
  output logic rst_pin_gpio_mode_reg
);

  // ----------------------------------------------------------------
  // Pin and reset synchronisers
  // ----------------------------------------------------------------
  logic pin_s1_reg;
  logic pin_s2_reg;
  logic por_s1_reg;
  logic por_s2_reg;
  logic [3:0] value_w;
  logic [3:0] value_reg;

  // Two flops on every pad-side input before use
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_reg <= 1'b0;
      pin_s2_reg <= 1'b0;
      por_s1_reg <= 1'b1;
      por_s2_reg <= 1'b1;
    end else begin
      pin_s1_reg <= port_a_bit7_line_in;
      pin_s2_reg <= pin_s1_reg;
      por_s1_reg <= por_req;
      por_s2_reg <= por_s1_reg;
    end
  end

  // ----------------------------------------------------------------
  // Reset source selection
  // ----------------------------------------------------------------
  logic pin_reset;
  logic any_reset;

  // Pin counts only while in reset-input function
  assign pin_reset = ~rst_pin_gpio_mode_reg & ~pin_s2_reg;
  // Remaining sources whatever the pin mode
  assign any_reset = pin_reset | por_s2_reg | watchdog_timeout_reset
                   | sw_reset_req;

  // ----------------------------------------------------------------
  // Internal reset sequencer
  // ----------------------------------------------------------------
  parmux_rst_e state_reg;
  parmux_rst_e state_next;
  logic [`PARMUX_RST_CNT_W-1:0] cnt_reg;
  logic [`PARMUX_RST_CNT_W-1:0] cnt_next;
  logic count_done;
  logic chip_rst_n_next;

  assign count_done = (cnt_reg == `PARMUX_RST_RELEASE_CYCLES - 8'h01);

  // Hold while any source active, then count, then release
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    case (state_reg)
      PARMUX_ST_HOLD: begin
        cnt_next = '0;
        if (!any_reset) state_next = PARMUX_ST_COUNT;
      end
      PARMUX_ST_COUNT: begin
        cnt_next = cnt_reg + 8'h01;
        if (any_reset) state_next = PARMUX_ST_HOLD;
        else if (count_done) state_next = PARMUX_ST_RUN;
      end
      PARMUX_ST_RUN: begin
        if (any_reset) state_next = PARMUX_ST_HOLD;
      end
      default: state_next = PARMUX_ST_HOLD;
    endcase
    if (any_reset) cnt_next = '0;
  end

  assign chip_rst_n_next = (state_next == PARMUX_ST_RUN);

  // Sequencer registers; release lands on a clock edge
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= PARMUX_ST_HOLD;
      cnt_reg <= '0;
      chip_rst_n_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      chip_rst_n_reg <= chip_rst_n_next;
    end
  end

  // ----------------------------------------------------------------
  // Reset pin function
  // ----------------------------------------------------------------
  // Mode only changes while running; any reset restores reset input
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_pin_gpio_mode_reg <= `PARMUX_RST_MODE_RESET;
    end else if (!chip_rst_n_reg || any_reset) begin
      rst_pin_gpio_mode_reg <= `PARMUX_RST_MODE_RESET;
    end else begin
      rst_pin_gpio_mode_reg <= rst_pin_gpio_sel;
    end
  end

  // ----------------------------------------------------------------
  // Pin cells
  // ----------------------------------------------------------------
  logic in_reset;
  parmux_cfg_s bit7_cfg;

  assign in_reset = ~chip_rst_n_reg;
  // Bit 7 has no alternate; only plain port use when in port mode
  assign bit7_cfg = '{dir_out: port_a_bit7_cfg.dir_out & rst_pin_gpio_mode_reg,
                      data_out: port_a_bit7_cfg.data_out & rst_pin_gpio_mode_reg,
                      alt_per: 1'b0, alt_sel: 1'b0};

  // Each cell owns its direction, so pins stay independent
  parmux_pin_cell u_bit0 (
    .sys_clk(sys_clk), .rst_n(rst_n), .in_reset(in_reset),
    .cfg(port_a_bit0_cfg), .alt_out(pulse_channel_zero),
    .pad_in(port_a_bit0_line_in), .pad(port_a_bit0_line), .pin_value(value_w[0]));
  parmux_pin_cell u_bit1 (
    .sys_clk(sys_clk), .rst_n(rst_n), .in_reset(in_reset),
    .cfg(port_a_bit1_cfg), .alt_out(pulse_channel_one),
    .pad_in(port_a_bit1_line_in), .pad(port_a_bit1_line), .pin_value(value_w[1]));
  parmux_pin_cell u_bit2 (
    .sys_clk(sys_clk), .rst_n(rst_n), .in_reset(in_reset),
    .cfg(port_a_bit2_cfg), .alt_out(pulse_channel_two),
    .pad_in(port_a_bit2_line_in), .pad(port_a_bit2_line), .pin_value(value_w[2]));
  parmux_pin_cell u_bit7 (
    .sys_clk(sys_clk), .rst_n(rst_n), .in_reset(in_reset),
    .cfg(bit7_cfg), .alt_out(1'b0),
    .pad_in(port_a_bit7_line_in), .pad(port_a_bit7_line), .pin_value());

  // Bit 7 value reads zero while the pin is the reset input
  assign value_w[3] = pin_s2_reg & rst_pin_gpio_mode_reg;

  // Registered read-back so the value output comes from a flop
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) value_reg <= '0;
    else value_reg <= value_w;
  end
  assign port_a_value = value_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_pin_holds_reset: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (pin_reset ##1 1'b1) |=> !chip_rst_n_reg)
    else $error("reset pin low but chip released");
  a_release_count: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(chip_rst_n_reg) |-> $past(state_reg) == PARMUX_ST_COUNT)
    else $error("release without full count");
  a_release_late: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (state_reg == PARMUX_ST_HOLD && !any_reset) ##1 (!any_reset)[*8]
    |-> !chip_rst_n_reg)
    else $error("release came too early");
  a_gpio_ignores_pin: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (rst_pin_gpio_mode_reg && chip_rst_n_reg && !por_s2_reg && !watchdog_timeout_reset
     && !sw_reset_req) |=> chip_rst_n_reg)
    else $error("pin resets chip in port mode");
  a_mode_returns: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !chip_rst_n_reg |=> !rst_pin_gpio_mode_reg)
    else $error("pin not back to reset function");
  a_wdog_resets: assert property (@(posedge sys_clk) disable iff (!rst_n)
    watchdog_timeout_reset |=> ##1 !chip_rst_n_reg)
    else $error("watchdog did not reset chip");
  a_reset_pullup: assert property (@(posedge sys_clk) disable iff (!rst_n)
    in_reset |=> port_a_bit0_line.oe_n && port_a_bit0_line.pull_up)
    else $error("pin not pulled-up input in reset");
  a_alt_needs_both: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (chip_rst_n_reg && !(port_a_bit1_cfg.alt_per && port_a_bit1_cfg.alt_sel)
     && !port_a_bit1_cfg.dir_out) |=> port_a_bit1_line.oe_n)
    else $error("alternate drove without both enables");
  a_alt_drives: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (chip_rst_n_reg && port_a_bit2_cfg.alt_per && port_a_bit2_cfg.alt_sel)
    |=> !port_a_bit2_line.oe_n && port_a_bit2_line.out == $past(pulse_channel_two))
    else $error("channel two not on pin");

endmodule : parmux_top
